//--- rtl/adc_conversion_sequencer.sv
// Notes on behaviour
// - Generic clock divided by internal prescaler.
// - Latency set by mode, resolution, gain.
// - Gain delay follows gain code table.
// - 8, 10, 12-bit; resets to 12.
// - Resolution write affects later conversions.
// - Differential bit selects signed conversions.
// - Both input modes in both run modes.
// - Free-running restarts conversions without triggers.
// - Ready flag set after every result; when accumulating, only after the last sample.
// - Start request synchronized before conversion.
// - Input sampled in first half period.
// - Sampling length field lengthens sampling.
// - Sum 2^code samples; reserved gives one.
// - Above 16 samples shift by code-4.
// - New result overwrites result register.
// - Unread result replaced sets overrun flag.
// - Start by software bit or trigger.
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
module adc_conversion_sequencer
    import adc_seq_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // Register port
    input wire logic [2:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    // Trigger
    input wire logic event_trigger_in,
    // Converter core
    input wire logic [11:0] conv_data_in,
    output logic sample_hold_out,
    output logic conv_active_out,
    output logic [3:0] input_gain_code_out,
    output logic differential_select_out,
    // Flags
    output logic result_ready_flag_out,
    output logic overrun_flag_out
);
    seq_link_if link ();

    clock_prescaler u_prescaler (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .link(link)
    );

    sample_accumulator u_accumulator (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .link(link)
    );

    // Gain delay in half conversion periods
    function automatic logic [2:0] gain_halves(input logic [3:0] gain,
                                               input logic diff, input logic free);
        logic [2:0] g;
        g = 3'h0;
        case (gain)
            4'h1: g = 3'h1;
            4'h2: g = 3'h2;
            4'h3: g = 3'h3;
            4'h4: g = 3'h4;
            4'hf: g = 3'h1;
            default: g = 3'h0;
        endcase
        if (free) begin
            if (diff) begin
                g = (gain == 4'hf) ? 3'h0 : {g[2:1], 1'b0};
            end else begin
                g = (gain == 4'hf) ? 3'h2 : 3'(((g + 3'h1) >> 1) << 1);
            end
        end else if (!diff) begin
            g = 3'(g + 3'h2);
        end
        return g;
    endfunction

    function automatic logic [6:0] res_bits(input logic [1:0] sel);
        case (sel)
            RES_10: res_bits = 7'd10;
            RES_8: res_bits = 7'd8;
            default: res_bits = 7'd12;
        endcase
    endfunction

    // Configuration registers
    logic free_q, free_d, diff_q, diff_d;
    logic [1:0] res_q, res_d;
    logic [2:0] presc_q, presc_d;
    logic [3:0] gain_q, gain_d, count_q, count_d;
    logic [5:0] samplen_q, samplen_d;
    logic wr_ctrl, wr_start, wr_flags, rd_result;

    always_comb begin
        wr_ctrl = reg_wr_in && reg_addr_in == ADDR_CONTROL;
        wr_start = reg_wr_in && reg_addr_in == ADDR_START;
        wr_flags = reg_wr_in && reg_addr_in == ADDR_FLAGS;
        rd_result = reg_rd_in && reg_addr_in == ADDR_RESULT;
        free_d = free_q;
        res_d = res_q;
        presc_d = presc_q;
        gain_d = gain_q;
        diff_d = diff_q;
        samplen_d = samplen_q;
        count_d = count_q;
        if (wr_ctrl) begin
            free_d = reg_wdata_in[FREE_RUN_POS];
            res_d = reg_wdata_in[RES_SEL_LSB +: 2];
            presc_d = reg_wdata_in[PRESC_LSB +: 3];
        end
        if (reg_wr_in && reg_addr_in == ADDR_INPUT) begin
            gain_d = reg_wdata_in[GAIN_LSB +: 4];
            diff_d = reg_wdata_in[DIFF_POS];
        end
        if (reg_wr_in && reg_addr_in == ADDR_SAMPLING) begin
            samplen_d = reg_wdata_in[5:0];
        end
        if (reg_wr_in && reg_addr_in == ADDR_ACCUM) begin
            count_d = reg_wdata_in[3:0];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            free_q <= 1'b0;
            res_q <= RES_SEL_RST;
            presc_q <= PRESC_RST;
            gain_q <= GAIN_RST;
            diff_q <= 1'b0;
            samplen_q <= SAMPLEN_RST;
            count_q <= COUNT_RST;
        end else begin
            free_q <= free_d;
            res_q <= res_d;
            presc_q <= presc_d;
            gain_q <= gain_d;
            diff_q <= diff_d;
            samplen_q <= samplen_d;
            count_q <= count_d;
        end
    end

    // Start request and its synchronizer
    logic pend_q, pend_d, sync1_q, sync2_q;
    seq_state_t state_q, state_d;
    logic [6:0] cnt_q, cnt_d, lat;
    logic [15:0] sample_ext;

    always_comb begin
        pend_d = pend_q;
        if (state_q != ST_IDLE) begin
            pend_d = 1'b0;
        end
        if ((wr_start && reg_wdata_in[START_POS]) || event_trigger_in) begin
            pend_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            pend_q <= 1'b0;
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            pend_q <= pend_d;
            sync1_q <= pend_q;
            sync2_q <= sync1_q;
        end
    end

    // Sequencing of sampling and conversion phases
    always_comb begin
        lat = 7'(res_bits(res_q) + 7'(gain_halves(gain_q, diff_q, free_q))
              + (free_q ? 7'd0 : 7'd2));
        case (res_q)
            RES_10: sample_ext = diff_q ? {{6{conv_data_in[9]}}, conv_data_in[9:0]}
                                        : {6'h00, conv_data_in[9:0]};
            RES_8: sample_ext = diff_q ? {{8{conv_data_in[7]}}, conv_data_in[7:0]}
                                       : {8'h00, conv_data_in[7:0]};
            default: sample_ext = diff_q ? {{4{conv_data_in[11]}}, conv_data_in}
                                         : {4'h0, conv_data_in};
        endcase
        state_d = state_q;
        cnt_d = cnt_q;
        link.acc_clear = 1'b0;
        link.acc_valid = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (sync2_q && link.tick) begin
                    state_d = ST_SAMPLE;
                    cnt_d = 7'(samplen_q) + 7'd1;
                    link.acc_clear = 1'b1;
                end
            end
            ST_SAMPLE: begin
                if (link.tick) begin
                    if (cnt_q == 7'd1) begin
                        state_d = ST_CONVERT;
                        cnt_d = 7'(lat - 7'd1);
                    end else begin
                        cnt_d = 7'(cnt_q - 7'd1);
                    end
                end
            end
            ST_CONVERT: begin
                if (link.tick) begin
                    if (cnt_q == 7'd1) begin
                        state_d = ST_DONE;
                        link.acc_valid = 1'b1;
                    end else begin
                        cnt_d = 7'(cnt_q - 7'd1);
                    end
                end
            end
            ST_DONE: begin
                if (free_q || !link.acc_done) begin
                    state_d = ST_SAMPLE;
                    cnt_d = 7'(samplen_q) + 7'd1;
                end else begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
                cnt_d = 7'd0;
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            state_q <= ST_IDLE;
            cnt_q <= 7'd0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    assign link.presc_code = presc_q;
    assign link.acc_signed = diff_q;
    assign link.acc_data = sample_ext;
    assign link.acc_code = (res_q == RES_ACC) ? count_q : 4'hf;

    // Result, flags and read port
    logic [15:0] result_q, result_d, rdata_q, rdata_d;
    logic ready_q, ready_d, overrun_q, overrun_d;

    always_comb begin
        result_d = result_q;
        ready_d = ready_q;
        overrun_d = overrun_q;
        if (rd_result) begin
            ready_d = 1'b0;
        end
        if (wr_flags && reg_wdata_in[READY_POS]) begin
            ready_d = 1'b0;
        end
        if (wr_flags && reg_wdata_in[OVERRUN_POS]) begin
            overrun_d = 1'b0;
        end
        if (link.acc_done) begin
            result_d = link.acc_result;
            ready_d = 1'b1;
            if (ready_q && !rd_result) begin
                overrun_d = 1'b1;
            end
        end
        rdata_d = 16'h0000;
        if (reg_rd_in) begin
            case (reg_addr_in)
                ADDR_CONTROL: rdata_d = {9'h000, presc_q, 1'b0, res_q, free_q};
                ADDR_INPUT: rdata_d = {11'h000, diff_q, gain_q};
                ADDR_SAMPLING: rdata_d = {10'h000, samplen_q};
                ADDR_ACCUM: rdata_d = {12'h000, count_q};
                ADDR_FLAGS: rdata_d = {14'h0000, overrun_q, ready_q};
                ADDR_RESULT: rdata_d = result_q;
                ADDR_STATUS: rdata_d = {12'h000, state_q};
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            result_q <= 16'h0000;
            ready_q <= 1'b0;
            overrun_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            result_q <= result_d;
            ready_q <= ready_d;
            overrun_q <= overrun_d;
            rdata_q <= rdata_d;
        end
    end

    assign sample_hold_out = (state_q == ST_SAMPLE);
    assign conv_active_out = (state_q != ST_IDLE);
    assign input_gain_code_out = gain_q;
    assign differential_select_out = diff_q;
    assign result_ready_flag_out = ready_q;
    assign overrun_flag_out = overrun_q;
    assign reg_rdata_out = rdata_q;

    property p_ready_set;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        link.acc_done |=> ready_q;
    endproperty
    a_ready_set: assert property (p_ready_set)
        else $error("ready flag not set after result");

    property p_result_load;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        link.acc_done |=> result_q == $past(link.acc_result);
    endproperty
    a_result_load: assert property (p_result_load)
        else $error("result register not overwritten");

    property p_overrun;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (link.acc_done && ready_q && !rd_result) |=> overrun_q;
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun not flagged");

    property p_latency;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (state_q == ST_SAMPLE && link.tick && cnt_q == 7'd1)
        |=> (state_q == ST_CONVERT && cnt_q == $past(lat) - 7'd1);
    endproperty
    a_latency: assert property (p_latency)
        else $error("conversion count wrong");

    property p_sample_len;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (state_q == ST_IDLE && sync2_q && link.tick)
        |=> (sample_hold_out && cnt_q == 7'($past(samplen_q)) + 7'd1);
    endproperty
    a_sample_len: assert property (p_sample_len)
        else $error("sampling length not applied");

    property p_start_sync;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (state_q == ST_IDLE) ##1 (state_q == ST_SAMPLE) |-> $past(sync2_q);
    endproperty
    a_start_sync: assert property (p_start_sync)
        else $error("conversion began without synced start");

    property p_free_run;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (state_q == ST_DONE && free_q) |=> state_q == ST_SAMPLE;
    endproperty
    a_free_run: assert property (p_free_run)
        else $error("free-running did not restart");

    property p_res_write;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        wr_ctrl |=> res_q == $past(reg_wdata_in[RES_SEL_LSB +: 2]);
    endproperty
    a_res_write: assert property (p_res_write)
        else $error("resolution write lost");

    property p_acc_more;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (state_q == ST_DONE && !link.acc_done) |=> state_q == ST_SAMPLE;
    endproperty
    a_acc_more: assert property (p_acc_more)
        else $error("accumulation stopped early");
endmodule // adc_conversion_sequencer

//--- common/adc_seq_pkg.sv
package adc_seq_pkg;
    // Register indices on the plain register port
    localparam logic [2:0] ADDR_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_INPUT = 3'h1;
    localparam logic [2:0] ADDR_SAMPLING = 3'h2;
    localparam logic [2:0] ADDR_ACCUM = 3'h3;
    localparam logic [2:0] ADDR_START = 3'h4;
    localparam logic [2:0] ADDR_FLAGS = 3'h5;
    localparam logic [2:0] ADDR_RESULT = 3'h6;
    localparam logic [2:0] ADDR_STATUS = 3'h7;
    // Field positions
    localparam int FREE_RUN_POS = 0;
    localparam int RES_SEL_LSB = 1;
    localparam int PRESC_LSB = 4;
    localparam int GAIN_LSB = 0;
    localparam int DIFF_POS = 4;
    localparam int START_POS = 0;
    localparam int READY_POS = 0;
    localparam int OVERRUN_POS = 1;
    // Resolution select codes
    localparam logic [1:0] RES_12 = 2'h0;
    localparam logic [1:0] RES_ACC = 2'h1;
    localparam logic [1:0] RES_10 = 2'h2;
    localparam logic [1:0] RES_8 = 2'h3;
    // Reset values
    localparam logic [1:0] RES_SEL_RST = RES_12;
    localparam logic [2:0] PRESC_RST = 3'h0;
    localparam logic [3:0] GAIN_RST = 4'h0;
    localparam logic [5:0] SAMPLEN_RST = 6'h00;
    localparam logic [3:0] COUNT_RST = 4'h0;
    // Accumulation limits
    localparam logic [3:0] COUNT_MAX = 4'ha;
    localparam logic [3:0] SHIFT_FREE = 4'h4;
    localparam int SUM_W = 23;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SAMPLE = 4'b0010,
        ST_CONVERT = 4'b0100,
        ST_DONE = 4'b1000
    } seq_state_t;
endpackage

//--- common/seq_link_if.sv
`timescale 1ns/1ps
interface seq_link_if;
    logic [2:0] presc_code;
    logic tick;
    logic acc_clear;
    logic acc_valid;
    logic acc_signed;
    logic [15:0] acc_data;
    logic [3:0] acc_code;
    logic acc_done;
    logic [15:0] acc_result;
    modport pre (input presc_code, output tick);
    modport acc (input acc_clear, acc_valid, acc_signed, acc_data, acc_code,
                 output acc_done, acc_result);
    modport seq (output presc_code, acc_clear, acc_valid, acc_signed, acc_data,
                 acc_code, input tick, acc_done, acc_result);
endinterface

//--- rtl/clock_prescaler.sv
`timescale 1ns/1ps
module clock_prescaler
    import adc_seq_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // Sequencer side
    seq_link_if.pre link
);
    logic [7:0] cnt_q, cnt_d, limit;
    logic tick_q, tick_d;

    // Half conversion period is 2^(code+1) generic clocks
    always_comb begin
        limit = 8'((9'h002 << link.presc_code) - 9'h001);
        tick_d = (cnt_q >= limit);
        cnt_d = tick_d ? 8'h00 : 8'(cnt_q + 8'h01);
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            cnt_q <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign link.tick = tick_q;
endmodule // clock_prescaler

//--- rtl/sample_accumulator.sv
`timescale 1ns/1ps
module sample_accumulator
    import adc_seq_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // Sequencer side
    seq_link_if.acc link
);
    logic [SUM_W-1:0] sum_q, sum_d, sum_new, ext;
    logic [10:0] cnt_q, cnt_d, target;
    logic [3:0] shift;
    logic done_q, done_d;
    logic [15:0] res_q, res_d;

    always_comb begin
        target = (link.acc_code <= COUNT_MAX) ? (11'h001 << link.acc_code) : 11'h001;
        shift = (link.acc_code > SHIFT_FREE && link.acc_code <= COUNT_MAX)
              ? 4'(link.acc_code - SHIFT_FREE) : 4'h0;
        ext = link.acc_signed ? {{(SUM_W-16){link.acc_data[15]}}, link.acc_data}
                              : {{(SUM_W-16){1'b0}}, link.acc_data};
        sum_new = 23'((cnt_q == 11'h000 ? 23'h000000 : sum_q) + ext);
        sum_d = sum_q;
        cnt_d = cnt_q;
        done_d = 1'b0;
        res_d = res_q;
        if (link.acc_clear) begin
            cnt_d = 11'h000;
        end else if (link.acc_valid) begin
            sum_d = sum_new;
            if (11'(cnt_q + 11'h001) >= target) begin
                cnt_d = 11'h000;
                done_d = 1'b1;
                res_d = link.acc_signed ? 16'($signed(sum_new) >>> shift)
                                        : 16'(sum_new >> shift);
            end else begin
                cnt_d = 11'(cnt_q + 11'h001);
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            sum_q <= 23'h000000;
            cnt_q <= 11'h000;
            done_q <= 1'b0;
            res_q <= 16'h0000;
        end else begin
            sum_q <= sum_d;
            cnt_q <= cnt_d;
            done_q <= done_d;
            res_q <= res_d;
        end
    end

    assign link.acc_done = done_q;
    assign link.acc_result = res_q;
endmodule // sample_accumulator

//--- verif/conv_core_model.sv
`timescale 1ns/1ps
module conv_core_model (
    // Clock
    input wire logic core_clk_in,
    // Sequencer side
    input wire logic sample_hold_in,
    input wire logic conv_active_in,
    output logic [11:0] conv_data_out,
    // Analog level and phase counts
    input wire logic [11:0] level_in,
    output int sample_cycles_out,
    output int conv_cycles_out,
    output int last_conv_out,
    output int samples_out
);
    logic [11:0] held = 12'h000;
    logic sh_prev = 1'b0;
    int samp_cnt = 0;
    int conv_cnt = 0;
    int prev_conv = 0;
    int starts = 0;
    always @(posedge core_clk_in) begin
        sh_prev <= sample_hold_in;
        if (sample_hold_in && !sh_prev) begin
            held <= level_in;
            samp_cnt <= 1;
            prev_conv <= conv_cnt;
            conv_cnt <= 0;
            starts <= starts + 1;
        end else if (sample_hold_in) begin
            samp_cnt <= samp_cnt + 1;
        end else if (conv_active_in) begin
            conv_cnt <= conv_cnt + 1;
        end
    end
    assign sample_cycles_out = samp_cnt;
    assign conv_cycles_out = conv_cnt;
    assign last_conv_out = prev_conv;
    assign samples_out = starts;
    // Result lines show junk outside conversions
    assign conv_data_out = conv_active_in ? held : ~held;
endmodule // conv_core_model

//--- verif/tb.sv
`timescale 1ns/1ps
module tb;
    import adc_seq_pkg::*;
    logic core_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [2:0] reg_addr_in = 3'h0;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic event_trigger_in = 1'b0;
    logic [11:0] level = 12'h000;
    logic [15:0] reg_rdata_out;
    logic [15:0] rd_val;
    logic [11:0] conv_data_in;
    logic sample_hold_out;
    logic conv_active_out;
    logic differential_select_out;
    logic result_ready_flag_out;
    logic overrun_flag_out;
    logic [3:0] input_gain_code_out;
    int sample_cycles;
    int conv_cycles;
    int last_conv;
    int samples;
    int fail_count = 0;
    int checks_done = 0;
    int s0;
    int k;
    logic [3:0] gl [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'hf};
    logic [3:0] ac [6] = '{4'h2, 4'h5, 4'hb, 4'h5, 4'h2, 4'ha};
    logic [11:0] al [6] = '{12'h123, 12'hfff, 12'h123, 12'hf00, 12'h010, 12'hfff};
    logic [15:0] ae [6] = '{16'h048c, 16'hfff0, 16'h0123, 16'hf000, 16'h0040, 16'hfff0};

    always #50 core_clk_in = ~core_clk_in;

    adc_conversion_sequencer dut (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .event_trigger_in(event_trigger_in), .conv_data_in(conv_data_in),
        .sample_hold_out(sample_hold_out), .conv_active_out(conv_active_out),
        .input_gain_code_out(input_gain_code_out),
        .differential_select_out(differential_select_out),
        .result_ready_flag_out(result_ready_flag_out), .overrun_flag_out(overrun_flag_out));

    conv_core_model core (.core_clk_in(core_clk_in), .sample_hold_in(sample_hold_out),
        .conv_active_in(conv_active_out), .conv_data_out(conv_data_in), .level_in(level),
        .sample_cycles_out(sample_cycles), .conv_cycles_out(conv_cycles),
        .last_conv_out(last_conv), .samples_out(samples));

    task automatic results();
        $display("counts: %0d checks, %0d mismatches", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        #1 rd_val = reg_rdata_out;
    endtask

    function automatic int lat(int res, logic [3:0] g, logic d, logic fr);
        int x;
        x = (g == 4'hf) ? 1 : ((g <= 4'h4) ? int'(g) : 0);
        if (fr)
            return res + (d ? (x / 2) * 2 : ((x + 1) / 2) * 2);
        return res + (d ? x : x + 2) + 2;
    endfunction

    task automatic conv(input logic [15:0] ctl, input logic [15:0] inp, input logic [5:0] sl,
                        input logic [11:0] lvl, input logic trig, input int n);
        int b;
        int i;
        logic early;
        b = samples;
        i = 0;
        early = 1'b0;
        level <= lvl;
        wr(ADDR_CONTROL, ctl);
        wr(ADDR_INPUT, inp);
        wr(ADDR_SAMPLING, {10'h000, sl});
        if (trig) begin
            @(posedge core_clk_in);
            event_trigger_in <= 1'b1;
            @(posedge core_clk_in);
            event_trigger_in <= 1'b0;
        end else begin
            wr(ADDR_START, 16'h0001);
        end
        @(posedge core_clk_in);
        #1 chk("sync delay", 16'h0000, {15'h0, sample_hold_out});
        while ((samples - b < n || conv_active_out !== 1'b0) && i < 60000) begin
            @(posedge core_clk_in);
            #1 i++;
            if (n > 1 && samples - b < n && result_ready_flag_out === 1'b1)
                early = 1'b1;
        end
        chk("conversion finished", 16'h0000, 16'(i >= 60000));
        repeat (3) @(posedge core_clk_in);
        #1 chk("ready flag", 16'h0001, {15'h0, result_ready_flag_out});
        chk("ready only after last", 16'h0000, {15'h0, early});
    endtask

    task automatic timed(input logic [15:0] ctl, input logic [15:0] inp, input logic [5:0] sl,
                         input logic [11:0] lvl, input int res, input int hp);
        conv(ctl, inp, sl, lvl, 1'b0, 1);
        chk("sample cycles", 16'((1 + sl) * hp), 16'(sample_cycles));
        chk("convert cycles", 16'((lat(res, inp[3:0], inp[4], 0) - 1) * hp + 1),
            16'(conv_cycles));
        chk("gain out", {12'h000, inp[3:0]}, {12'h000, input_gain_code_out});
        chk("diff out", {15'h0, inp[4]}, {15'h0, differential_select_out});
        rd(ADDR_RESULT);
        chk("result", {4'h0, lvl}, rd_val);
        chk("ready cleared", 16'h0000, {15'h0, result_ready_flag_out});
    endtask

    initial begin
        #(100 * 95000);
        fail_count++;
        results();
    end

    initial begin
        repeat (16) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        rd(ADDR_CONTROL);
        chk("control reset", 16'h0000, rd_val);
        rd(ADDR_STATUS);
        chk("status reset", 16'h0001, rd_val);
        rd(ADDR_FLAGS);
        chk("flags reset", 16'h0000, rd_val);
        $display("test reset done");
        // Single-ended and differential for positive levels
        for (int g = 0; g < 7; g++)
            for (int d = 0; d < 2; d++)
                timed(16'h0000, {11'h000, d[0], gl[g]}, 6'h00, 12'h3a5, 12, 2);
        $display("test gain delay done");
        timed(16'h0004, 16'h0000, 6'h00, 12'h2ab, 10, 2);
        timed(16'h0006, 16'h0000, 6'h00, 12'h0ab, 8, 2);
        timed(16'h0010, 16'h0000, 6'h02, 12'h123, 12, 4);
        $display("test resolution and prescaler done");
        conv(16'h0000, 16'h0010, 6'h00, 12'h800, 1'b1, 1);
        rd(ADDR_RESULT);
        chk("negative result", 16'hf800, rd_val);
        $display("test trigger done");
        for (int a = 0; a < 6; a++) begin
            wr(ADDR_ACCUM, {12'h000, ac[a]});
            k = (ac[a] > 4'ha) ? 1 : (1 << ac[a]);
            conv(16'h0002, {11'h000, a == 3, 4'h0}, 6'h00, al[a], 1'b0, k);
            rd(ADDR_RESULT);
            chk("accumulated", ae[a], rd_val);
        end
        wr(ADDR_ACCUM, 16'h0000);
        $display("test accumulation done");
        conv(16'h0000, 16'h0000, 6'h00, 12'h111, 1'b0, 1);
        conv(16'h0000, 16'h0000, 6'h00, 12'h222, 1'b0, 1);
        chk("overrun flag", 16'h0001, {15'h0, overrun_flag_out});
        rd(ADDR_RESULT);
        chk("newest result", 16'h0222, rd_val);
        rd(ADDR_FLAGS);
        chk("flags after read", 16'h0002, rd_val);
        wr(ADDR_FLAGS, 16'h0002);
        rd(ADDR_FLAGS);
        chk("flags cleared", 16'h0000, rd_val);
        $display("test overrun done");
        wr(ADDR_CONTROL, 16'h0001);
        wr(ADDR_INPUT, 16'h0003);
        wr(ADDR_START, 16'h0001);
        s0 = samples;
        k = 0;
        while (samples - s0 < 4 && k < 3000) begin
            @(posedge core_clk_in);
            #1 k++;
        end
        chk("free restarts", 16'h0001, 16'(samples - s0 >= 4));
        chk("free convert", 16'((lat(12, 4'h3, 1'b0, 1'b1) - 1) * 2 + 1), 16'(last_conv));
        #1 chk("free ready", 16'h0001, {15'h0, result_ready_flag_out});
        rd(ADDR_RESULT);
        wr(ADDR_INPUT, 16'h0013);
        s0 = samples;
        k = 0;
        while (samples - s0 < 3 && k < 3000) begin
            @(posedge core_clk_in);
            #1 k++;
        end
        chk("free samples", 16'h0001, 16'(samples - s0 >= 3));
        chk("free ready again", 16'h0001, {15'h0, result_ready_flag_out});
        chk("free diff convert", 16'((lat(12, 4'h3, 1'b1, 1'b1) - 1) * 2 + 1),
            16'(last_conv));
        chk("free diff out", 16'h0001, {15'h0, differential_select_out});
        wr(ADDR_CONTROL, 16'h0000);
        k = 0;
        while (conv_active_out !== 1'b0 && k < 3000) begin
            @(posedge core_clk_in);
            #1 k++;
        end
        chk("free stops", 16'h0000, 16'(k >= 3000));
        $display("test free running done");
        results();
    end
endmodule // tb
